// *** hw/cmd_queue.sv ***
// command word queue held in flip-flops, with flush
`timescale 1ns/1ps
`default_nettype none
module cmd_queue #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic empty,
    output logic full
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } q_state_type;
    q_state_type cur_r;
    q_state_type nxt;
    logic do_push;
    logic do_pop;

    // status and head word
    assign empty = (cur_r.cnt == '0);
    assign full = (cur_r.cnt == (AW+1)'(DEPTH));
    assign head = cur_r.mem[cur_r.rp];

    // push drops when full, pop ignored when empty
    always_comb begin
        nxt = cur_r;
        do_push = push && !full;
        do_pop = pop && !empty;
        if (do_push) begin
            nxt.mem[cur_r.wp] = push_data;
            nxt.wp = cur_r.wp + 1'b1;
        end
        if (do_pop) begin
            nxt.rp = cur_r.rp + 1'b1;
        end
        nxt.cnt = cur_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
        if (flush) begin
            nxt.wp = '0;
            nxt.rp = '0;
            nxt.cnt = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_r <= '0;
        end else begin
            cur_r <= nxt;
        end
    end
endmodule : cmd_queue
`default_nettype wire

// *** hw/edge_gen_consts.svh ***
// offsets, field positions, reset values and timing counts of the edge generator
`ifndef EDGE_GEN_CONSTS_SVH
`define EDGE_GEN_CONSTS_SVH
`define CTRL_OFS 12'h000
`define RT_STAT_OFS 12'h004
`define LATCH_STAT_OFS 12'h008
`define Q1_WR_OFS 12'h00c
`define Q2_WR_OFS 12'h010
`define CTRL_RES_BIT 0
`define CTRL_RST_BIT 2
`define CTRL_PAUSE_BIT 4
`define CTRL_RESET_VAL 6'h00
`define RT_LEVEL_BIT 2
`define CODE_REPEAT 4'h0
`define CODE_FRAC 4'h1
`define CODE_SETREF 4'h2
`define CODE_TOGGLE1 4'hf
`define Q_DEPTH 16
`define WORD_W 22
`define NS_PER_SEC 33'h0_3b9a_ca00
`define CLK_PERIOD_NS 5
`define MIN_GAP_NS 16
`define MIN_GAP_CYC ((`MIN_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELEASE_NS 8
`define RELEASE_CYC ((`RELEASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** hw/edge_gen_pkg.sv ***
// types shared by the edge generator files
package edge_gen_pkg;
    typedef enum logic [2:0] {
        ST_FETCH = 3'b000,
        ST_ABS = 3'b001,
        ST_REL2 = 3'b010,
        ST_NORM = 3'b011,
        ST_WAIT = 3'b100
    } gen_st_type;
    typedef struct packed {
        logic notify;
        logic release_pin;
        logic [3:0] code;
        logic [15:0] data;
    } cmd_word_type;
    typedef struct packed {
        logic [47:0] sec;
        logic [29:0] ns;
        logic [7:0] frac;
    } tod_type;
    typedef struct packed {
        gen_st_type st;
        cmd_word_type [15:0] hist;
        cmd_word_type cmd;
        logic [2:0] wcnt;
        logic [47:0] sec;
        logic [32:0] ns;
        logic [7:0] frac;
        logic [15:0] off_hi;
        logic rep_on;
        logic rep_inf;
        logic rep_frac;
        logic rep_ph;
        logic [3:0] rep_hi;
        logic [3:0] rep_lo;
        logic [3:0] rep_idx;
        logic [11:0] rep_cnt;
        logic [8:0] m1cnt;
        logic [8:0] m2cnt;
        logic [2:0] gap;
    } gen_state_type;
    typedef struct packed {
        gen_state_type [1:0] gen;
        logic [5:0] ctrl;
        logic [1:0] done;
        logic [31:0] rdata;
    } top_state_type;
    typedef struct packed {
        logic level;
        logic oe;
        logic [1:0] relcnt;
    } drv_state_type;
endpackage : edge_gen_pkg

// *** hw/pin_driver.sv ***
// output level and drive enable of one generator
`timescale 1ns/1ps
`default_nettype none
`include "edge_gen_consts.svh"
module pin_driver (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic srst,
    input wire logic fire,
    input wire logic lvl_in,
    input wire logic rel,
    output logic level,
    output logic oe
);
    import edge_gen_pkg::*;
    drv_state_type cur_r;
    drv_state_type nxt;

    assign level = cur_r.level;
    assign oe = cur_r.oe;

    // new edge drives, release counts down then lets go
    always_comb begin
        nxt = cur_r;
        if (srst) begin
            nxt.level = 1'b0;
            nxt.oe = 1'b1;
            nxt.relcnt = '0;
        end else if (fire) begin
            nxt.level = lvl_in;
            nxt.oe = 1'b1;
            nxt.relcnt = rel ? 2'(`RELEASE_CYC) : 2'h0;
        end else if (cur_r.relcnt != '0) begin
            nxt.relcnt = cur_r.relcnt - 2'h1;
            if (cur_r.relcnt == 2'h1) begin
                nxt.oe = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_r <= 4'h4;
        end else begin
            cur_r <= nxt;
        end
    end
endmodule : pin_driver
`default_nettype wire

// *** hw/time_triggered_edge_generator.sv ***
// two time-triggered edge generators with apb registers
// What this block does
// - code 0000 replays last N entries M times; M zero repeats until a fresh word enters the queue
// - code 0001 is fractional synthesis over four entries, M1 bits 15:8, M2 bits 7:0
// - single-word toggles: entries 1,2 repeat M1 times, then 3,4 M2 times
// - two-word toggles: command in entries 3,4 repeats 2*M2 times
// - fractional pattern cycles until a fresh word enters the queue
// - code 0010 captures current time as reference; data ignored
// - bits 19:18 pick rise, fall or toggle; bits 17:16 pick time format
// - absolute edge takes five words: seconds 47:0 then ns 29:0
// - 32-bit relative edge takes two words; second code field ignored
// - 16-bit relative edge is one word holding the offset
// - relative edge lands offset after the previous event
// - fine bit makes relative offsets count 1/256 ns
// - reset control empties queue, resets logic, drives output low
// - pause finishes current command or group, then fetches nothing
// - full flag reads one while a queue is full
// - two generators, each written through its own register
// - repeat gives periods in steps of 2 ns or 2/256 ns
// - each queue holds sixteen 22-bit entries
// - notify bit sets the latched done bit when the command ends
// - release bit lets the pin float two reference periods after the edge
// - relative edge no closer than 16 ns after the previous one
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "edge_gen_consts.svh"
module time_triggered_edge_generator (
    input wire logic ref_clk,
    input wire logic rst,
    input wire edge_gen_pkg::tod_type tod,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [1:0] gen_out,
    output logic [1:0] gen_oe
);
    import edge_gen_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [2:0] decode(input logic [11:0] a);
        if (a == `CTRL_OFS) decode = 3'h0;
        else if (a == `RT_STAT_OFS) decode = 3'h1;
        else if (a == `LATCH_STAT_OFS) decode = 3'h2;
        else if (a == `Q1_WR_OFS) decode = 3'h3;
        else if (a == `Q2_WR_OFS) decode = 3'h4;
        else decode = 3'h7;
    endfunction : decode

    function automatic logic time_ge(input tod_type t, input gen_state_type s);
        time_ge = {t.sec, t.ns, t.frac} >= {s.sec, s.ns[29:0], s.frac};
    endfunction : time_ge

    function automatic gen_state_type add_rel(input gen_state_type s, input logic [31:0] off,
                                              input logic fine);
        logic [8:0] fs;
        fs = {1'b0, s.frac} + {1'b0, off[7:0]};
        add_rel = s;
        if (fine) begin
            add_rel.frac = fs[7:0];
            add_rel.ns = s.ns + {9'h0, off[31:8]} + {32'h0, fs[8]};
        end else begin
            add_rel.ns = s.ns + {1'b0, off};
        end
    endfunction : add_rel

    top_state_type cur_r;
    top_state_type nxt;
    cmd_word_type [1:0] head;
    logic [1:0] empty;
    logic [1:0] full;
    logic [1:0] pop;
    logic [1:0] push;
    logic [1:0] fire;
    logic [1:0] lvl;
    logic [1:0] rel;
    logic [1:0] done_set;
    logic [1:0] level;
    logic [1:0] srst;
    logic [2:0] sel;
    logic wr;

    // ==========================================================
    // apb slave
    assign sel = decode(paddr);
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (sel == 3'h7);
    assign prdata = cur_r.rdata;
    assign srst = cur_r.ctrl[`CTRL_RST_BIT +: 2];
    assign gen_out = level;

    // queue writes, dropped when full or lanes missing
    always_comb begin
        push[0] = wr && (sel == 3'h3) && (&pstrb[2:0]);
        push[1] = wr && (sel == 3'h4) && (&pstrb[2:0]);
    end

    // ==========================================================
    // per generator queue and pin
    for (genvar g = 0; g < 2; g++) begin : gen_blk
        cmd_queue #(
            .WIDTH(`WORD_W),
            .DEPTH(`Q_DEPTH)
        ) queue_i (
            .ref_clk(ref_clk),
            .rst(rst),
            .flush(srst[g]),
            .push(push[g]),
            .push_data(pwdata[`WORD_W-1:0]),
            .pop(pop[g]),
            .head(head[g]),
            .empty(empty[g]),
            .full(full[g])
        );
        pin_driver drv_i (
            .ref_clk(ref_clk),
            .rst(rst),
            .srst(srst[g]),
            .fire(fire[g]),
            .lvl_in(lvl[g]),
            .rel(rel[g]),
            .level(level[g]),
            .oe(gen_oe[g])
        );
    end

    // ==========================================================
    // registers and command engines
    always_comb begin
        cmd_word_type w;
        logic avail;
        gen_state_type s;
        w = '0;
        avail = 1'b0;
        s = '0;
        nxt = cur_r;
        pop = '0;
        fire = '0;
        lvl = '0;
        rel = '0;
        done_set = '0;
        for (int g = 0; g < 2; g++) begin
            s = cur_r.gen[g];
            if (s.gap != '0) begin
                s.gap = s.gap - 3'h1;
            end
            // replay words first, queue words only if not paused between commands
            if (s.rep_on) begin
                w = s.hist[s.rep_idx];
                avail = 1'b1;
            end else begin
                w = head[g];
                avail = !empty[g] && (!cur_r.ctrl[`CTRL_PAUSE_BIT + g] || s.st != ST_FETCH);
            end
            case (s.st)
                ST_FETCH: begin
                    if (avail) begin
                        s.cmd = w;
                        if (w.code == `CODE_REPEAT) begin
                            if (!s.rep_on && w.data[3:0] != 4'h0) begin
                                s.rep_hi = w.data[3:0] - 4'h1;
                                s.rep_lo = 4'h0;
                                s.rep_idx = w.data[3:0] - 4'h1;
                                s.rep_cnt = w.data[15:4];
                                s.rep_inf = (w.data[15:4] == 12'h0);
                                s.rep_frac = 1'b0;
                                s.rep_on = 1'b1;
                            end
                        end else if (w.code == `CODE_FRAC) begin
                            if (!s.rep_on) begin
                                // single-word toggles count pairs once, two-word ones twice
                                if (s.hist[3].code == `CODE_TOGGLE1) begin
                                    s.m1cnt = {1'b0, w.data[15:8]};
                                    s.m2cnt = {1'b0, w.data[7:0]};
                                end else begin
                                    s.m1cnt = {w.data[15:8], 1'b0};
                                    s.m2cnt = {w.data[7:0], 1'b0};
                                end
                                s.rep_hi = 4'h3;
                                s.rep_lo = 4'h2;
                                s.rep_idx = 4'h3;
                                s.rep_cnt = {3'h0, s.m1cnt};
                                s.rep_ph = 1'b0;
                                s.rep_frac = 1'b1;
                                s.rep_inf = 1'b0;
                                s.rep_on = 1'b1;
                            end
                        end else if (w.code == `CODE_SETREF) begin
                            s.sec = tod.sec;
                            s.ns = {3'h0, tod.ns};
                            s.frac = tod.frac;
                            done_set[g] = w.notify;
                        end else if (w.code[3:2] != 2'h0 && w.code[1:0] != 2'h0) begin
                            case (w.code[1:0])
                                2'h1: begin
                                    s.sec = {32'h0, w.data};
                                    s.wcnt = 3'h1;
                                    s.st = ST_ABS;
                                end
                                2'h2: begin
                                    s.off_hi = w.data;
                                    s.st = ST_REL2;
                                end
                                default: begin
                                    s = add_rel(s, {16'h0, w.data}, cur_r.ctrl[g]);
                                    s.st = ST_NORM;
                                end
                            endcase
                        end
                    end
                end
                ST_ABS: begin
                    if (avail) begin
                        s.wcnt = s.wcnt + 3'h1;
                        if (s.wcnt < 3'h4) begin
                            s.sec = {s.sec[31:0], w.data};
                        end else if (s.wcnt == 3'h4) begin
                            s.ns = {19'h0, w.data[13:0]};
                        end else begin
                            s.ns = {3'h0, s.ns[13:0], w.data};
                            s.frac = 8'h0;
                            s.st = ST_NORM;
                        end
                    end
                end
                ST_REL2: begin
                    if (avail) begin
                        s = add_rel(s, {s.off_hi, w.data}, cur_r.ctrl[g]);
                        s.st = ST_NORM;
                    end
                end
                ST_NORM: begin
                    // carry whole seconds out of the nanosecond field
                    if (s.ns >= `NS_PER_SEC) begin
                        s.ns = s.ns - `NS_PER_SEC;
                        s.sec = s.sec + 48'h1;
                    end else begin
                        s.st = ST_WAIT;
                    end
                end
                default: begin
                    if (cur_r.gen[g].gap == 3'h0 && time_ge(tod, s)) begin
                        fire[g] = 1'b1;
                        lvl[g] = (s.cmd.code[3:2] == 2'h1) ||
                                 (s.cmd.code[3:2] == 2'h3 && !level[g]);
                        rel[g] = s.cmd.release_pin;
                        done_set[g] = s.cmd.notify;
                        s.gap = 3'(`MIN_GAP_CYC - 1);
                        s.st = ST_FETCH;
                    end
                end
            endcase
            // consumption: queue pop and history, or replay cursor
            if (avail && s.st != ST_WAIT && cur_r.gen[g].st != ST_NORM
                && cur_r.gen[g].st != ST_WAIT) begin
                if (cur_r.gen[g].rep_on) begin
                    if (s.rep_idx != s.rep_lo) begin
                        s.rep_idx = s.rep_idx - 4'h1;
                    end else if (!s.rep_frac) begin
                        if ((!s.rep_inf && s.rep_cnt <= 12'h1) || (s.rep_inf && !empty[g])) begin
                            s.rep_on = 1'b0;
                        end else begin
                            s.rep_idx = s.rep_hi;
                            s.rep_cnt = s.rep_inf ? s.rep_cnt : s.rep_cnt - 12'h1;
                        end
                    end else if (s.rep_cnt > 12'h1) begin
                        s.rep_cnt = s.rep_cnt - 12'h1;
                        s.rep_idx = s.rep_hi;
                    end else if (!s.rep_ph) begin
                        s.rep_ph = 1'b1;
                        s.rep_hi = 4'h1;
                        s.rep_lo = 4'h0;
                        s.rep_idx = 4'h1;
                        s.rep_cnt = {3'h0, s.m2cnt};
                    end else if (!empty[g]) begin
                        s.rep_on = 1'b0;
                    end else begin
                        s.rep_ph = 1'b0;
                        s.rep_hi = 4'h3;
                        s.rep_lo = 4'h2;
                        s.rep_idx = 4'h3;
                        s.rep_cnt = {3'h0, s.m1cnt};
                    end
                end else begin
                    pop[g] = 1'b1;
                    if (!(cur_r.gen[g].st == ST_FETCH && w.code[3:1] == 3'h0)) begin
                        s.hist = {s.hist[14:0], w};
                    end
                end
            end
            nxt.gen[g] = srst[g] ? gen_state_type'('0) : s;
        end
        // control writes
        if (wr && sel == 3'h0 && pstrb[0]) begin
            nxt.ctrl = pwdata[5:0];
        end
        // latched done bits, write one clears, a new event wins
        nxt.done = cur_r.done;
        if (wr && sel == 3'h2 && pstrb[0]) begin
            nxt.done = cur_r.done & ~pwdata[1:0];
        end
        nxt.done = nxt.done | done_set;
        // read data captured in the setup phase
        if (psel && !penable && !pwrite) begin
            if (sel == 3'h0) nxt.rdata = {26'h0, cur_r.ctrl};
            else if (sel == 3'h1) nxt.rdata = {28'h0, level, full};
            else if (sel == 3'h2) nxt.rdata = {30'h0, cur_r.done};
            else nxt.rdata = 32'h0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_r <= '0;
        end else begin
            cur_r <= nxt;
        end
    end

    // ==========================================================
    // checks
    for (genvar g = 0; g < 2; g++) begin : chk_blk
        soft_rst_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
            srst[g] |=> cur_r.gen[g].st == ST_FETCH && !cur_r.gen[g].rep_on && empty[g])
            else $error("soft reset left engine busy");
        soft_rst_low_a: assert property (@(posedge ref_clk) disable iff (rst)
            srst[g] |=> !level[g] && gen_oe[g])
            else $error("soft reset did not drive low");
        pause_no_fetch_a: assert property (@(posedge ref_clk) disable iff (rst)
            cur_r.ctrl[`CTRL_PAUSE_BIT + g] && cur_r.gen[g].st == ST_FETCH
            && !cur_r.gen[g].rep_on |-> !pop[g])
            else $error("fetch while paused");
        edge_gap_a: assert property (@(posedge ref_clk) disable iff (rst)
            fire[g] |=> !fire[g] [*3])
            else $error("edges closer than 16 ns");
        edge_time_a: assert property (@(posedge ref_clk) disable iff (rst)
            fire[g] |-> time_ge(tod, cur_r.gen[g]) && cur_r.gen[g].st == ST_WAIT)
            else $error("edge before its time");
        rise_level_a: assert property (@(posedge ref_clk) disable iff (rst || srst[g])
            fire[g] && cur_r.gen[g].cmd.code[3:2] == 2'h1 |=> level[g])
            else $error("rising edge missing");
        toggle_level_a: assert property (@(posedge ref_clk) disable iff (rst || srst[g])
            fire[g] && cur_r.gen[g].cmd.code[3:2] == 2'h3 |=> level[g] != $past(level[g]))
            else $error("toggle kept level");
        release_float_a: assert property (@(posedge ref_clk) disable iff (rst || srst[g])
            fire[g] && rel[g] |=> gen_oe[g] ##1 gen_oe[g] ##1 !gen_oe[g])
            else $error("release timing wrong");
        notify_done_a: assert property (@(posedge ref_clk) disable iff (rst)
            fire[g] && cur_r.gen[g].cmd.notify |=> cur_r.done[g])
            else $error("done bit not set");
        full_read_a: assert property (@(posedge ref_clk) disable iff (rst)
            psel && !penable && !pwrite && sel == 3'h1 |=> prdata[g] == $past(full[g]))
            else $error("full flag misread");
        repeat_seen_c: cover property (@(posedge ref_clk) disable iff (rst)
            cur_r.gen[g].rep_on && !cur_r.gen[g].rep_frac && fire[g]);
        frac_phase_c: cover property (@(posedge ref_clk) disable iff (rst)
            cur_r.gen[g].rep_frac && cur_r.gen[g].rep_ph && fire[g]);
        abs_edge_c: cover property (@(posedge ref_clk) disable iff (rst)
            cur_r.gen[g].st == ST_ABS ##[1:20] fire[g]);
    end
endmodule : time_triggered_edge_generator
`default_nettype wire

// *** verification/time_triggered_edge_generator_test.sv ***
// self-checking bench for the time-triggered edge generator
`timescale 1ns/1ps
`default_nettype none
`include "edge_gen_consts.svh"
module time_triggered_edge_generator_test;
    import edge_gen_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    tod_type tod = '0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] gen_out;
    logic [1:0] gen_oe;
    logic [31:0] rd;
    logic err;
    logic [29:0] tgt;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int t0;
    time_triggered_edge_generator dut (.ref_clk(ref_clk), .rst(rst), .tod(tod), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gen_out(gen_out), .gen_oe(gen_oe));
    // 200 mhz clock
    always #2.5 ref_clk = ~ref_clk;
    // time engine advancing 5 ns a cycle, and the hang limit
    always @(posedge ref_clk) begin
        tod.ns <= tod.ns + 30'd5;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    // waits for a level change of one output, sampled mid-cycle, then realigns to a rising edge
    task automatic wait_edge(input int b);
        int n;
        logic v;
        n = 0;
        @(negedge ref_clk);
        v = gen_out[b];
        while (gen_out[b] === v && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
    endtask : wait_edge
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk({28'h0, gen_oe, gen_out}, 32'hc);
        apb(1'b0, `CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0f0, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset and map done");
        // paused generator keeps its queue, full flag rises at sixteen
        apb(1'b1, `CTRL_OFS, 32'h10);
        for (int i = 0; i < `Q_DEPTH; i++) begin
            apb(1'b0, `RT_STAT_OFS, 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, `Q1_WR_OFS, 32'hf0014);
        end
        apb(1'b0, `RT_STAT_OFS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, `CTRL_OFS, 32'h14);
        apb(1'b0, `RT_STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        $display("test queue full and flush done");
        // square wave of 20 ns half period
        apb(1'b1, `CTRL_OFS, 32'h10);
        apb(1'b1, `Q1_WR_OFS, 32'h20000);
        apb(1'b1, `Q1_WR_OFS, 32'hf0014);
        apb(1'b1, `Q1_WR_OFS, 32'h00001);
        apb(1'b1, `CTRL_OFS, 32'h0);
        wait_edge(0);
        for (int i = 0; i < 3; i++) begin
            t0 = cyc;
            wait_edge(0);
            chk(cyc - t0, 32'h4);
        end
        chk({30'h0, gen_oe}, 32'h3);
        $display("test square wave done");
        // absolute rise with notify on the second generator, then released toggle
        tgt = tod.ns + 30'd400;
        apb(1'b1, `Q2_WR_OFS, 32'h250000);
        apb(1'b1, `Q2_WR_OFS, 32'h50000);
        apb(1'b1, `Q2_WR_OFS, 32'h50000);
        apb(1'b1, `Q2_WR_OFS, {12'h0, 4'h5, 2'h0, tgt[29:16]});
        apb(1'b1, `Q2_WR_OFS, {16'h5, tgt[15:0]});
        apb(1'b1, `Q2_WR_OFS, 32'h1f0050);
        wait_edge(1);
        chk({31'h0, tod.ns >= tgt && tod.ns <= tgt + 30'd15}, 32'h1);
        chk({31'h0, gen_out[1]}, 32'h1);
        apb(1'b0, `LATCH_STAT_OFS, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, `LATCH_STAT_OFS, 32'h2);
        apb(1'b0, `LATCH_STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        wait_edge(1);
        chk({31'h0, tod.ns >= tgt + 30'd80 && tod.ns <= tgt + 30'd95}, 32'h1);
        t0 = cyc;
        while (gen_oe[1] !== 1'b0 && cyc < t0 + 20) @(negedge ref_clk);
        chk(cyc - t0, 32'h2);
        $display("test absolute and release done");
        // two replays of a fine-resolution 32-bit toggle of 30 ns on the second generator
        @(posedge ref_clk);
        apb(1'b1, `CTRL_OFS, 32'h22);
        apb(1'b1, `Q2_WR_OFS, 32'h20000);
        apb(1'b1, `Q2_WR_OFS, 32'he0000);
        apb(1'b1, `Q2_WR_OFS, 32'he1e00);
        apb(1'b1, `Q2_WR_OFS, 32'h00022);
        apb(1'b1, `CTRL_OFS, 32'h2);
        wait_edge(1);
        for (int i = 0; i < 2; i++) begin
            t0 = cyc;
            wait_edge(1);
            chk(cyc - t0, 32'h6);
        end
        repeat (20) @(posedge ref_clk);
        chk({31'h0, gen_out[1]}, 32'h1);
        $display("test fine repeat done");
        wrap_up();
    end
endmodule : time_triggered_edge_generator_test
`default_nettype wire
